// ===== core/lp2_pkg.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: Shared constants and types for the bank state tracker
// Assumes: 100 MHz core clock; command pins sampled through synchronisers
// Notes:   Times are printed in ns; cycle counts derive from them
//////////////////////////////////////////////////////////////////////////////
package lp2_pkg;

   // Core clock
   localparam int CLK_PERIOD_NS = 10;

   // Least times, rounded up to whole core cycles, never below one
   function automatic int lp2_cyc_up(input int ns);
      int c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction

   localparam int PRECHARGE_PERIOD_NS = 18;
   localparam int ACTIVATE_TO_ACCESS_DELAY_NS = 18;
   localparam int BANK_REFRESH_CYCLE_TIME_NS = 60;
   localparam int ALL_BANK_REFRESH_CYCLE_TIME_NS = 130;
   localparam int MODE_READ_PERIOD_NS = 20;
   localparam int MODE_WRITE_PERIOD_NS = 50;
   localparam int POWERDOWN_EXIT_TIME_NS = 8;
   localparam int BURST_DURATION_NS = 40;

   localparam int PRECHARGE_PERIOD_CYC = lp2_cyc_up(PRECHARGE_PERIOD_NS);
   localparam int ACTIVATE_TO_ACCESS_DELAY_CYC = lp2_cyc_up(ACTIVATE_TO_ACCESS_DELAY_NS);
   localparam int BANK_REFRESH_CYCLE_TIME_CYC = lp2_cyc_up(BANK_REFRESH_CYCLE_TIME_NS);
   localparam int ALL_BANK_REFRESH_CYCLE_TIME_CYC = lp2_cyc_up(ALL_BANK_REFRESH_CYCLE_TIME_NS);
   localparam int MODE_READ_PERIOD_CYC = lp2_cyc_up(MODE_READ_PERIOD_NS);
   localparam int MODE_WRITE_PERIOD_CYC = lp2_cyc_up(MODE_WRITE_PERIOD_NS);
   localparam int POWERDOWN_EXIT_TIME_CYC = lp2_cyc_up(POWERDOWN_EXIT_TIME_NS);
   localparam int BURST_DURATION_CYC = lp2_cyc_up(BURST_DURATION_NS);

   // Widths and field positions on the command/address bus
   localparam int CA_W = 10;
   localparam int TMR_W = 8;
   localparam int BANK_W = 3;
   localparam int CA_BA_LSB = 7;
   localparam int CA_AUTO_BIT = 0;
   localparam int CA_AB_BIT = 4;
   localparam int CA_MA_LSB = 4;
   localparam int CA_MA_W = 6;
   localparam logic [CA_MA_W-1:0] RESET_MA = 6'h3F;
   localparam int SYNC_W = CA_W + 3;

   typedef enum logic [3:0] {
      CMD_NOP   = 4'h0,
      CMD_ACT   = 4'h1,
      CMD_RD    = 4'h2,
      CMD_WR    = 4'h3,
      CMD_PRE   = 4'h4,
      CMD_STOP = 4'h5,
      CMD_REFPB = 4'h6,
      CMD_REFAB = 4'h7,
      CMD_MODE_RD = 4'h8,
      CMD_MODE_WR = 4'h9,
      CMD_RESET = 4'hA
   } lp2_cmd_e;

   typedef enum logic [3:0] {
      BK_POWER_ON    = 4'h0,
      BK_IDLE        = 4'h1,
      BK_ACTIVATING  = 4'h2,
      BK_ACTIVE      = 4'h3,
      BK_READING     = 4'h4,
      BK_WRITING     = 4'h5,
      BK_READ_AUTO = 4'h6,
      BK_WRITE_AUTO = 4'h7,
      BK_PRECHARGING = 4'h8,
      BK_REFRESHING = 4'h9,
      BK_MODE_RD_IDLE = 4'hA,
      BK_MODE_RD_ACTIVE = 4'hB,
      BK_MR_WRITING = 4'hC,
      BK_RESETTING = 4'hD,
      BK_MODE_RD_RESET = 4'hE
   } lp2_bank_e;

   typedef struct packed {
      lp2_cmd_e kind;
      logic [BANK_W-1:0] bank;
      logic autoPrecharge;
      logic allBanks;
   } lp2_cmd_s;

endpackage

// ===== core/lp2_pin_sync.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: Two-stage synchroniser for the device pins
// Assumes: Pins change slowly against the core clock
// Notes:   Stage one feeds stage two and nothing else
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module lp2_pin_sync
   import lp2_pkg::*;
#(
   parameter int W = SYNC_W
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic [W-1:0] pinIn,
   output logic [W-1:0] pinSync
);

   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   always_ff @(posedge clk) begin
      if (!rstn) begin
         meta_q <= '0;
         sync_q <= '0;
      end else if (ce) begin
         meta_q <= pinIn;
         sync_q <= meta_q;
      end
   end

   assign pinSync = sync_q;

endmodule

// ===== core/lp2_bank_timer.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: Per-bank down-counter for timed bank states
// Assumes: Load value is the state length in core cycles
// Notes:   Loading zero cancels a running period
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module lp2_bank_timer
   import lp2_pkg::*;
#(
   parameter int W = TMR_W
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic load,
   input wire logic [W-1:0] loadVal,
   output logic busy,
   output logic done
);

   logic [W-1:0] cnt_q;

   always_ff @(posedge clk) begin
      if (!rstn) begin
         cnt_q <= '0;
      end else if (ce) begin
         if (load) begin
            cnt_q <= loadVal;
         end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end

   assign busy = (cnt_q != '0);
   // Last cycle of the period: the owner advances on this edge
   assign done = ce && (cnt_q == {{(W-1){1'b0}}, 1'b1});

endmodule

// ===== core/lp2_bank_tracker.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: Same-bank command state tracker of a four-bank mobile DDR SDRAM
// Assumes: Controller drives CS#, CA and CKE referenced to the device clock
// Notes:   Device clock is sampled by the core clock; no data path here
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps

module lp2_bank_tracker
   import lp2_pkg::*;
#(
   parameter int NUM_BANKS = 4,
   parameter int PRECHARGE_CYC = PRECHARGE_PERIOD_CYC,
   parameter int ACT_CYC = ACTIVATE_TO_ACCESS_DELAY_CYC,
   parameter int REFPB_CYC = BANK_REFRESH_CYCLE_TIME_CYC,
   parameter int REFAB_CYC = ALL_BANK_REFRESH_CYCLE_TIME_CYC,
   parameter int MODE_RD_CYC = MODE_READ_PERIOD_CYC,
   parameter int MODE_WR_CYC = MODE_WRITE_PERIOD_CYC,
   parameter int PDX_CYC = POWERDOWN_EXIT_TIME_CYC,
   parameter int BURST_CYC = BURST_DURATION_CYC
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic devClk,
   input wire logic cke,
   input wire logic csN,
   input wire logic [CA_W-1:0] ca,
   output lp2_bank_e [NUM_BANKS-1:0] bankState,
   output logic illegalCmd,
   output logic cmdAccepted,
   output lp2_cmd_s lastCmd
);

   //////////////////////////////////////////////////////////////////////////
   // Pin capture

   logic [SYNC_W-1:0] pinSync;
   logic devClkS;
   logic ckeS;
   logic csNS;
   logic [CA_W-1:0] caS;
   logic devClkPrev_q;
   logic riseEv;
   logic fallEv;

   lp2_pin_sync #(.W(SYNC_W)) uSync (
      .clk(clk),
      .rstn(rstn),
      .ce(ce),
      .pinIn({devClk, cke, csN, ca}),
      .pinSync(pinSync)
   );

   assign {devClkS, ckeS, csNS, caS} = pinSync;
   assign riseEv = devClkS && !devClkPrev_q;
   assign fallEv = !devClkS && devClkPrev_q;

   always_ff @(posedge clk) begin
      if (!rstn) begin
         devClkPrev_q <= 1'b0;
      end else if (ce) begin
         devClkPrev_q <= devClkS;
      end
   end

   // Rising-edge half of the command, CKE history
   logic [CA_W-1:0] caRise_q;
   logic csNRise_q;
   logic ckeCur_q;
   logic ckePrev_q;
   logic riseSeen_q;

   always_ff @(posedge clk) begin
      if (!rstn) begin
         caRise_q <= '0;
         csNRise_q <= 1'b1;
         ckeCur_q <= 1'b0;
         ckePrev_q <= 1'b0;
         riseSeen_q <= 1'b0;
      end else if (ce) begin
         if (riseEv) begin
            caRise_q <= caS;
            csNRise_q <= csNS;
            ckeCur_q <= ckeS;
            ckePrev_q <= ckeCur_q;
            riseSeen_q <= 1'b1;
         end else if (fallEv) begin
            riseSeen_q <= 1'b0;
         end
      end
   end

   // Power-down exit: hold commands off for the exit time
   logic [TMR_W-1:0] xpCnt_q;

   always_ff @(posedge clk) begin
      if (!rstn) begin
         xpCnt_q <= '0;
      end else if (ce) begin
         if (riseEv && !ckeCur_q && ckeS) begin
            xpCnt_q <= TMR_W'(PDX_CYC);
         end else if (xpCnt_q != '0) begin
            xpCnt_q <= xpCnt_q - 1'b1;
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Command decode, completed at the falling edge (auto-precharge travels there)

   lp2_cmd_s cmd;
   logic cmdFire;

   always_comb begin
      cmd.bank = caRise_q[CA_BA_LSB +: BANK_W];
      cmd.autoPrecharge = caS[CA_AUTO_BIT];
      cmd.allBanks = caRise_q[CA_AB_BIT];
      cmd.kind = CMD_NOP;
      if (!csNRise_q) begin
         casez (caRise_q[3:0])
            4'b0000: cmd.kind = (caRise_q[CA_MA_LSB +: CA_MA_W] == RESET_MA) ? CMD_RESET : CMD_MODE_WR;
            4'b1000: cmd.kind = CMD_MODE_RD;
            4'b1100: cmd.kind = CMD_REFAB;
            4'b0100: cmd.kind = CMD_REFPB;
            4'b??10: cmd.kind = CMD_ACT;
            4'b?001: cmd.kind = CMD_WR;
            4'b?101: cmd.kind = CMD_RD;
            4'b1011: cmd.kind = CMD_PRE;
            4'b0011: cmd.kind = CMD_STOP;
            default: cmd.kind = CMD_NOP;
         endcase
      end
   end

   // Only with CKE high at this and the previous rising edge and exit time met
   assign cmdFire = fallEv && riseSeen_q && ckePrev_q && ckeCur_q && (xpCnt_q == '0)
                    && (cmd.kind != CMD_NOP);

   //////////////////////////////////////////////////////////////////////////
   // Bank state

   lp2_bank_e [NUM_BANKS-1:0] state_q;
   lp2_bank_e [NUM_BANKS-1:0] eff;
   lp2_bank_e [NUM_BANKS-1:0] nxt;
   logic [NUM_BANKS-1:0] tmrLoad;
   logic [NUM_BANKS-1:0] tmrDone;
   logic [NUM_BANKS-1:0] badVec;
   logic [NUM_BANKS-1:0][TMR_W-1:0] tmrVal;
   logic [BANK_W-1:0] lastBank_q;
   logic anyBad;

   // Post-period state, so a command in the final cycle sees the result
   function automatic lp2_bank_e after_period(input lp2_bank_e s);
      case (s)
         BK_ACTIVATING: after_period = BK_ACTIVE;
         BK_READING: after_period = BK_ACTIVE;
         BK_WRITING: after_period = BK_ACTIVE;
         BK_READ_AUTO: after_period = BK_IDLE;
         BK_WRITE_AUTO: after_period = BK_IDLE;
         BK_PRECHARGING: after_period = BK_IDLE;
         BK_REFRESHING: after_period = BK_IDLE;
         BK_MODE_RD_IDLE: after_period = BK_IDLE;
         BK_MODE_RD_ACTIVE: after_period = BK_ACTIVE;
         BK_MR_WRITING: after_period = BK_IDLE;
         BK_MODE_RD_RESET: after_period = BK_IDLE;
         default: after_period = s;
      endcase
   endfunction

   // Device-wide conditions
   logic allIdle;
   logic allPowerOn;
   logic allResetting;
   logic allIdleOrActive;

   always_comb begin
      allIdle = 1'b1;
      allPowerOn = 1'b1;
      allResetting = 1'b1;
      allIdleOrActive = 1'b1;
      for (int i = 0; i < NUM_BANKS; i++) begin
         allIdle &= (eff[i] == BK_IDLE);
         allPowerOn &= (eff[i] == BK_POWER_ON);
         allResetting &= (eff[i] == BK_RESETTING);
         allIdleOrActive &= (eff[i] == BK_IDLE) || (eff[i] == BK_ACTIVE);
      end
   end

   assign anyBad = |badVec;

   for (genvar b = 0; b < NUM_BANKS; b++) begin : gBank
      logic sel;
      logic inBurst;

      assign sel = (cmd.bank == BANK_W'(b));

      lp2_bank_timer #(.W(TMR_W)) uTimer (
         .clk(clk),
         .rstn(rstn),
         .ce(ce),
         .load(tmrLoad[b] && !anyBad),
         .loadVal(tmrVal[b]),
         .busy(),
         .done(tmrDone[b])
      );

      assign eff[b] = tmrDone[b] ? after_period(state_q[b]) : state_q[b];
      assign inBurst = (eff[b] == BK_READING) || (eff[b] == BK_WRITING);

      always_comb begin
         nxt[b] = eff[b];
         tmrLoad[b] = 1'b0;
         tmrVal[b] = '0;
         badVec[b] = 1'b0;
         if (cmdFire) begin
            case (cmd.kind)
               CMD_ACT: begin
                  if (sel) begin
                     if (eff[b] == BK_IDLE) begin
                        nxt[b] = BK_ACTIVATING;
                        tmrLoad[b] = 1'b1;
                        tmrVal[b] = TMR_W'(ACT_CYC);
                     end else begin
                        badVec[b] = 1'b1;
                     end
                  end
               end
               CMD_RD, CMD_WR: begin
                  // Open row or plain read/write burst (chained) takes it; every other bank state refuses
                  if (sel) begin
                     if (eff[b] == BK_ACTIVE || inBurst) begin
                        tmrLoad[b] = 1'b1;
                        if (cmd.autoPrecharge) begin
                           nxt[b] = (cmd.kind == CMD_RD) ? BK_READ_AUTO : BK_WRITE_AUTO;
                           tmrVal[b] = TMR_W'(BURST_CYC + PRECHARGE_CYC);
                        end else begin
                           nxt[b] = (cmd.kind == CMD_RD) ? BK_READING : BK_WRITING;
                           tmrVal[b] = TMR_W'(BURST_CYC);
                        end
                     end else begin
                        badVec[b] = 1'b1;
                     end
                  end
               end
               CMD_PRE: begin
                  if (sel || cmd.allBanks) begin
                     if (eff[b] == BK_IDLE || eff[b] == BK_ACTIVE) begin
                        nxt[b] = BK_PRECHARGING;
                        tmrLoad[b] = 1'b1;
                        tmrVal[b] = TMR_W'(PRECHARGE_CYC);
                     end else begin
                        badVec[b] = 1'b1;
                     end
                  end
               end
               CMD_STOP: begin
                  // Follows the latest burst, not the address on the bus
                  if (lastBank_q == BANK_W'(b)) begin
                     if (inBurst) begin
                        nxt[b] = BK_ACTIVE;
                        tmrLoad[b] = 1'b1;
                        tmrVal[b] = '0;
                     end else begin
                        badVec[b] = 1'b1;
                     end
                  end
               end
               CMD_REFPB: begin
                  if (sel) begin
                     if (NUM_BANKS == 8 && eff[b] == BK_IDLE) begin
                        nxt[b] = BK_REFRESHING;
                        tmrLoad[b] = 1'b1;
                        tmrVal[b] = TMR_W'(REFPB_CYC);
                     end else begin
                        badVec[b] = 1'b1;
                     end
                  end
               end
               CMD_REFAB: begin
                  if (allIdle) begin
                     nxt[b] = BK_REFRESHING;
                     tmrLoad[b] = 1'b1;
                     tmrVal[b] = TMR_W'(REFAB_CYC);
                  end else begin
                     badVec[b] = 1'b1;
                  end
               end
               CMD_MODE_RD: begin
                  tmrLoad[b] = 1'b1;
                  tmrVal[b] = TMR_W'(MODE_RD_CYC);
                  if (allResetting) begin
                     nxt[b] = BK_MODE_RD_RESET;
                  end else if (allIdleOrActive) begin
                     nxt[b] = (eff[b] == BK_IDLE) ? BK_MODE_RD_IDLE : BK_MODE_RD_ACTIVE;
                  end else begin
                     badVec[b] = 1'b1;
                  end
               end
               CMD_MODE_WR: begin
                  if (allIdle) begin
                     nxt[b] = BK_MR_WRITING;
                     tmrLoad[b] = 1'b1;
                     tmrVal[b] = TMR_W'(MODE_WR_CYC);
                  end else begin
                     badVec[b] = 1'b1;
                  end
               end
               CMD_RESET: begin
                  if (allIdle || allPowerOn) begin
                     nxt[b] = BK_RESETTING;
                     tmrLoad[b] = 1'b1;
                     tmrVal[b] = '0;
                  end else begin
                     badVec[b] = 1'b1;
                  end
               end
               default: nxt[b] = eff[b];
            endcase
         end
      end

      // A refused command leaves every bank as it was
      always_ff @(posedge clk) begin
         if (!rstn) begin
            state_q[b] <= BK_POWER_ON;
         end else if (ce) begin
            state_q[b] <= anyBad ? eff[b] : nxt[b];
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Burst owner and reporting

   always_ff @(posedge clk) begin
      if (!rstn) begin
         lastBank_q <= '0;
      end else if (ce) begin
         if (cmdFire && !anyBad && (cmd.kind == CMD_RD || cmd.kind == CMD_WR)) begin
            lastBank_q <= cmd.bank;
         end
      end
   end

   logic illegal_q;
   logic accepted_q;
   lp2_cmd_s lastCmd_q;

   always_ff @(posedge clk) begin
      if (!rstn) begin
         illegal_q <= 1'b0;
         accepted_q <= 1'b0;
         lastCmd_q <= '{kind: CMD_NOP, bank: '0, autoPrecharge: 1'b0, allBanks: 1'b0};
      end else if (ce) begin
         illegal_q <= cmdFire && anyBad;
         accepted_q <= cmdFire && !anyBad;
         if (cmdFire) begin
            lastCmd_q <= cmd;
         end
      end
   end

   assign bankState = state_q;
   assign illegalCmd = illegal_q;
   assign cmdAccepted = accepted_q;
   assign lastCmd = lastCmd_q;

endmodule

// ===== bench/lp2_ctrl_model.sv
// Purpose: Controller model driving the command/address link
// Assumes: One command per 125 ns frame
// Notes:   Device clock stands still between frames
`timescale 1ns/1ps
module lp2_ctrl_model
   import lp2_pkg::*;
(
   output logic devClk,
   output logic cke,
   output logic csN,
   output logic [CA_W-1:0] ca
);
   initial begin
      devClk = 1'b0;
      cke = 1'b1;
      csN = 1'b1;
      ca = 10'h000;
   end
   ////////////////////////////////////////////////////////////////////////////
   // Deselected between frames, so only no-ops reach timed states
   task automatic issue(input logic [CA_W-1:0] r, input logic autoPre, input logic ckeLvl);
      cke = ckeLvl;
      csN = 1'b0;
      ca = r;
      #31.25 devClk = 1'b1;
      #31.25 ca[CA_AUTO_BIT] = autoPre;
      #31.25 devClk = 1'b0;
      #31.25 csN = 1'b1;
      // Released bus must not keep looking valid
      ca = ~ca;
   endtask
endmodule

// ===== bench/lp2_tracker_properties.sv
// Purpose: Port-level checks of the bank state tracker
// Assumes: Default period parameters except burst length
// Notes:   Bank 1 carries the bench's row traffic
`timescale 1ns/1ps
module lp2_chk
   import lp2_pkg::*;
#(
   parameter int NUM_BANKS = 4,
   parameter int PRECHARGE_CYC = PRECHARGE_PERIOD_CYC,
   parameter int BURST_CYC = BURST_DURATION_CYC
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic devClk,
   input wire logic cke,
   input wire logic csN,
   input wire logic [CA_W-1:0] ca,
   input lp2_bank_e [NUM_BANKS-1:0] bankState,
   input wire logic illegalCmd,
   input wire logic cmdAccepted,
   input lp2_cmd_s lastCmd
);
   localparam int RAP_LAST = BURST_CYC + PRECHARGE_CYC - 1;
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   ////////////////////////////////////////////////////////////////////////////
   one_pulse_a: assert property (!(cmdAccepted && illegalCmd))
      else $error("accept and refuse together");
   refused_keeps_a: assert property (illegalCmd |-> $stable(bankState))
      else $error("refused command changed state");
   act_delay_a: assert property ($changed(bankState[1]) && bankState[1] == BK_ACTIVATING
      |=> bankState[1] == BK_ACTIVATING ##1 bankState[1] == BK_ACTIVE) else $error("activate delay wrong");
   pre_period_a: assert property ($changed(bankState[1]) && bankState[1] == BK_PRECHARGING
      |=> bankState[1] == BK_PRECHARGING ##1 bankState[1] == BK_IDLE) else $error("precharge period wrong");
   refab_len_a: assert property ($changed(bankState[0]) && bankState[0] == BK_REFRESHING
      |-> ##12 bankState[0] == BK_REFRESHING ##1 bankState[0] == BK_IDLE) else $error("refresh length wrong");
   mode_wr_len_a: assert property ($changed(bankState[0]) && bankState[0] == BK_MR_WRITING
      |-> (bankState[0] == BK_MR_WRITING)[*5] ##1 bankState[0] == BK_IDLE) else $error("mode write length wrong");
   mode_rd_active_a: assert property ($changed(bankState[1]) && bankState[1] == BK_MODE_RD_ACTIVE
      |-> (bankState[1] == BK_MODE_RD_ACTIVE)[*2] ##1 bankState[1] == BK_ACTIVE) else $error("active mode read wrong");
   mode_rd_reset_a: assert property ($changed(bankState[0]) && bankState[0] == BK_MODE_RD_RESET
      |-> (bankState[0] == BK_MODE_RD_RESET)[*2] ##1 bankState == {NUM_BANKS{BK_IDLE}}) else $error("init end wrong");
   read_autopre_a: assert property ($changed(bankState[1]) && bankState[1] == BK_READ_AUTO
      |-> ##RAP_LAST bankState[1] == BK_READ_AUTO ##1 bankState[1] == BK_IDLE) else $error("auto precharge wrong");
   stop_end_a: assert property (cmdAccepted && lastCmd.kind == CMD_STOP
      |-> bankState[1] == BK_ACTIVE && $past(bankState[1]) inside {BK_READING, BK_WRITING}) else $error("stop wrong");
   refpb_refused_a: assert property ((cmdAccepted || illegalCmd) && lastCmd.kind == CMD_REFPB
      |-> illegalCmd) else $error("bank refresh taken");
endmodule
bind lp2_bank_tracker lp2_chk #(.NUM_BANKS(NUM_BANKS), .PRECHARGE_CYC(PRECHARGE_CYC), .BURST_CYC(BURST_CYC)) u_lp2_chk (
   .clk(clk), .rstn(rstn), .ce(ce), .devClk(devClk), .cke(cke), .csN(csN), .ca(ca), .bankState(bankState),
   .illegalCmd(illegalCmd), .cmdAccepted(cmdAccepted), .lastCmd(lastCmd));

// ===== bench/testbench.sv
// Purpose: Self-checking bench of the bank state tracker
// Assumes: Controller model frames one command each
// Notes:   Burst length raised so stop and chained reads fit
`timescale 1ns/1ps
module testbench;
   import lp2_pkg::*;
   localparam int BURST = 40;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic ce = 1'b1;
   logic devClk, cke, csN, illegalCmd, cmdAccepted;
   logic [CA_W-1:0] ca;
   lp2_bank_e [3:0] bankState;
   lp2_bank_e [3:0] pst;
   lp2_cmd_s lastCmd;
   int errors = 0;
   int checks = 0;
   int cycles = 0;
   always #5 clk = ~clk;
   lp2_bank_tracker #(.BURST_CYC(BURST)) u_lp2_bank_tracker (.clk(clk), .rstn(rstn), .ce(ce), .devClk(devClk),
      .cke(cke), .csN(csN), .ca(ca), .bankState(bankState), .illegalCmd(illegalCmd), .cmdAccepted(cmdAccepted),
      .lastCmd(lastCmd));
   lp2_ctrl_model u_lp2_ctrl_model (.devClk(devClk), .cke(cke), .csN(csN), .ca(ca));
   ////////////////////////////////////////////////////////////////////////////
   task automatic complete_run();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         errors++;
         complete_run();
      end
   end
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      checks++;
      if (g !== e) begin
         errors++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask
   function automatic logic [15:0] one(input int i, input lp2_bank_e s, input lp2_bank_e r);
      lp2_bank_e [3:0] v;
      for (int k = 0; k < 4; k++) begin
         v[k] = r;
      end
      v[i] = s;
      return v;
   endfunction
   function automatic logic [CA_W-1:0] cav(input logic [3:0] n, input logic [2:0] b);
      return {b, 3'h0, n};
   endfunction
   // Mode: 0 refused, 1 taken, 2 ignored; state at the answer kept in pst
   task automatic cmd(input logic [CA_W-1:0] r, input logic autoPre, input logic ckeLvl, input int mode);
      logic acc;
      logic ill;
      acc = 1'b0;
      ill = 1'b0;
      fork
         u_lp2_ctrl_model.issue(r, autoPre, ckeLvl);
         repeat (14) begin
            @(posedge clk);
            #1;
            if (cmdAccepted === 1'b1 || illegalCmd === 1'b1) begin
               acc |= (cmdAccepted === 1'b1);
               ill |= (illegalCmd === 1'b1);
               pst = bankState;
            end
         end
      join
      chk("taken", {15'h0, mode == 1}, {15'h0, acc});
      chk("refused", {15'h0, mode == 0}, {15'h0, ill});
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic test_power_on();
      cmd(10'h007, 1'b0, 1'b1, 2);
      cmd(10'h007, 1'b0, 1'b1, 2);
      cmd(cav(4'h2, 3'h1), 1'b0, 1'b1, 0);
      chk("power-on kept", one(0, BK_POWER_ON, BK_POWER_ON), pst);
      chk("decoded kind", {12'h0, CMD_ACT}, {12'h0, lastCmd.kind});
      cmd(10'h3F0, 1'b0, 1'b0, 2);
      cmd(10'h3F0, 1'b0, 1'b1, 2);
      chk("cke low ignored", one(0, BK_POWER_ON, BK_POWER_ON), bankState);
      cmd(10'h007, 1'b0, 1'b1, 2);
   endtask
   task automatic test_init();
      cmd(10'h3F0, 1'b0, 1'b1, 1);
      chk("resetting", one(0, BK_RESETTING, BK_RESETTING), pst);
      cmd(cav(4'h8, 3'h0), 1'b0, 1'b1, 1);
      chk("reset read", one(0, BK_MODE_RD_RESET, BK_MODE_RD_RESET), pst);
      repeat (10) @(posedge clk);
      chk("idle after init", one(0, BK_IDLE, BK_IDLE), bankState);
   endtask
   task automatic test_device_wide();
      cmd(cav(4'h4, 3'h2), 1'b0, 1'b1, 0);
      cmd(cav(4'hC, 3'h0), 1'b0, 1'b1, 1);
      chk("refreshing", one(0, BK_REFRESHING, BK_REFRESHING), pst);
      repeat (15) @(posedge clk);
      chk("refresh end", one(0, BK_IDLE, BK_IDLE), bankState);
      cmd(10'h010, 1'b0, 1'b1, 1);
      chk("mode writing", one(0, BK_MR_WRITING, BK_MR_WRITING), pst);
      repeat (8) @(posedge clk);
      cmd(cav(4'h8, 3'h0), 1'b0, 1'b1, 1);
      chk("idle mode read", one(0, BK_MODE_RD_IDLE, BK_MODE_RD_IDLE), pst);
      repeat (5) @(posedge clk);
      chk("mode read end", one(0, BK_IDLE, BK_IDLE), bankState);
      cmd(cav(4'hB, 3'h2), 1'b0, 1'b1, 1);
      chk("idle precharge", one(2, BK_PRECHARGING, BK_IDLE), pst);
      repeat (5) @(posedge clk);
   endtask
   task automatic test_bank();
      cmd(cav(4'h2, 3'h1), 1'b0, 1'b1, 1);
      chk("activating", one(1, BK_ACTIVATING, BK_IDLE), pst);
      repeat (5) @(posedge clk);
      chk("active", one(1, BK_ACTIVE, BK_IDLE), bankState);
      cmd(cav(4'h8, 3'h0), 1'b0, 1'b1, 1);
      chk("active mode read", one(1, BK_MODE_RD_ACTIVE, BK_MODE_RD_IDLE), pst);
      repeat (5) @(posedge clk);
      chk("back to active", one(1, BK_ACTIVE, BK_IDLE), bankState);
      cmd(cav(4'hC, 3'h0), 1'b0, 1'b1, 0);
      cmd(10'h010, 1'b0, 1'b1, 0);
      cmd(cav(4'h5, 3'h1), 1'b0, 1'b1, 1);
      chk("reading", one(1, BK_READING, BK_IDLE), pst);
      cmd(cav(4'h5, 3'h1), 1'b1, 1'b1, 1);
      chk("read with precharge", one(1, BK_READ_AUTO, BK_IDLE), pst);
      chk("last command", {7'h0, CMD_RD, 3'h1, 1'b1, 1'b0}, {7'h0, lastCmd});
      repeat (BURST + PRECHARGE_PERIOD_CYC + 2) @(posedge clk);
      chk("auto precharge end", one(1, BK_IDLE, BK_IDLE), bankState);
      cmd(cav(4'h2, 3'h1), 1'b0, 1'b1, 1);
      repeat (5) @(posedge clk);
      cmd(cav(4'h1, 3'h1), 1'b0, 1'b1, 1);
      chk("writing", one(1, BK_WRITING, BK_IDLE), pst);
      cmd(cav(4'h3, 3'h2), 1'b0, 1'b1, 1);
      chk("stopped", one(1, BK_ACTIVE, BK_IDLE), pst);
      cmd(cav(4'h3, 3'h1), 1'b0, 1'b1, 0);
      cmd(cav(4'h5, 3'h1), 1'b0, 1'b1, 1);
      // Clock enable low must hold the burst timer
      @(posedge clk);
      ce <= 1'b0;
      repeat (BURST + 2) @(posedge clk);
      chk("frozen burst", one(1, BK_READING, BK_IDLE), bankState);
      ce <= 1'b1;
      repeat (BURST + 2) @(posedge clk);
      chk("burst self end", one(1, BK_ACTIVE, BK_IDLE), bankState);
      cmd(cav(4'hB, 3'h1), 1'b0, 1'b1, 1);
      chk("precharging", one(1, BK_PRECHARGING, BK_IDLE), pst);
      repeat (5) @(posedge clk);
      chk("idle again", one(1, BK_IDLE, BK_IDLE), bankState);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (19) @(posedge clk);
      #1;
      chk("reset state", one(0, BK_POWER_ON, BK_POWER_ON), bankState);
      chk("reset flags", 16'h0000, {14'h0, illegalCmd, cmdAccepted});
      chk("reset kind", {12'h0, CMD_NOP}, {12'h0, lastCmd.kind});
      @(posedge clk);
      rstn <= 1'b1;
      repeat (5) @(posedge clk);
      test_power_on();
      test_init();
      test_device_wide();
      test_bank();
      complete_run();
   end
endmodule
